// *** cdd_pkg.sv ***
// Constants and carrier types shared by the character display instruction decoder
package cdd_pkg;

  // ---------------------------------------------------------------------------
  // Bus register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SCROLL = 8'h0C;

  // ---------------------------------------------------------------------------
  // Memory layout
  // ---------------------------------------------------------------------------
  localparam int PTR_W = 7;
  localparam int GLYPH_AW = 6;
  localparam int CHAR_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int SCROLL_W = 6;
  localparam int COL_W = 5;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [PTR_W-1:0] HOME_ADDR = 7'h00;
  localparam logic [PTR_W-1:0] LINE1_LAST = 7'h27;
  localparam logic [PTR_W-1:0] LINE2_FIRST = 7'h40;
  localparam logic [PTR_W-1:0] LINE2_LAST = 7'h67;
  localparam logic [GLYPH_AW-1:0] GLYPH_LAST = 6'h3F;
  localparam logic [SCROLL_W-1:0] SCROLL_ZERO = 6'h00;
  localparam logic [SCROLL_W-1:0] SCROLL_LAST = 6'h27;
  localparam logic [SCROLL_W-1:0] LINE_LEN = 6'h28;

  // ---------------------------------------------------------------------------
  // Instruction byte fields
  // ---------------------------------------------------------------------------
  localparam int BIT_CHAR_SET = 7;
  localparam int BIT_GLYPH_SET = 6;
  localparam int BIT_FUNC = 5;
  localparam int BIT_SHIFT = 4;
  localparam int BIT_DISP = 3;
  localparam int BIT_ENTRY = 2;
  localparam int BIT_HOME = 1;
  localparam int BIT_CLEAR = 0;
  localparam int ENTRY_DIR_BIT = 1;
  localparam int ENTRY_SCROLL_BIT = 0;
  localparam int DISP_PANEL_BIT = 2;
  localparam int DISP_CURSOR_BIT = 1;
  localparam int DISP_BLINK_BIT = 0;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int FUNC_DL_BIT = 4;
  localparam int FUNC_N_BIT = 3;
  localparam int FUNC_LUM_HI_BIT = 1;
  localparam int FUNC_LUM_LO_BIT = 0;
  localparam logic BUSY_FLAG = 1'b0;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int BLINK_CNT_W = 25;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum {
    CDD_NOP, CDD_CLEAR, CDD_HOME, CDD_ENTRY, CDD_DISP,
    CDD_SHIFT, CDD_FUNC, CDD_GLYPH_SET, CDD_CHAR_SET
  } cdd_instr_t;

  typedef struct packed {
    logic stepUp;
    logic autoScroll;
    logic panelOn;
    logic cursorOn;
    logic blink;
    logic busWidth8;
    logic twoLines;
    logic [1:0] luminance;
  } cdd_cfg_t;

  localparam cdd_cfg_t CFG_RESET = '{
    stepUp: 1'b1, autoScroll: 1'b0, panelOn: 1'b0, cursorOn: 1'b0, blink: 1'b0,
    busWidth8: 1'b1, twoLines: 1'b1, luminance: 2'h0
  };

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } cdd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cdd_apb_rsp_t;

  typedef struct packed {
    logic [7:0] code;
    logic blank;
    logic cursorRow;
    logic allPixelsOn;
  } cdd_cell_t;

endpackage

// *** cdd_decoder.sv ***
// Instruction decoder, pointer, memories and display state of the character display
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - Home sets pointer to character address 00H, clears scroll, keeps RAMs.
// - Step-direction 0 decrements pointer per access; auto-scroll shifts right per write.
// - Step-direction 1 increments pointer per access; auto-scroll shifts left per write.
// - Entry mode stores both flags; no scroll on reads or glyph accesses.
// - Display control stores panel, cursor, blink; panel off blanks the display.
// - Cursor flag draws eighth pixel row at the pointer cell.
// - Blink alternates all-on cell with the character, about 1 Hz, half duty.
// - Shift steps pointer by direction; scroll select also shifts display.
// - After a shift the pointer always targets character RAM.
// - Function set bit 4 stores the 4-bit/8-bit bus width flag; every transfer stays byte wide.
// - Function set bit 3 picks one or two display lines.
// - Luminance bits pick full, three quarter, half or quarter brightness.
// - Glyph address set loads six bits and targets glyph RAM.
// - Character address set loads seven bits and targets character RAM.
// - Instruction read returns pointer with busy bit zero, changing nothing.
// - Every transfer is taken back to back with no execution delay.
// - Data write stores byte in chosen RAM, then steps and scrolls.
// - Data read returns byte from chosen RAM, then steps the pointer.
// - Reset fills character RAM with spaces, pointer 00H, no scroll.
// - Reset flags: step up, no scroll, panel off, 8-bit, two lines, full.
// - Entry, display and function instructions leave RAMs and pointer alone.
// - Character pointer wraps 27H/40H and 67H/00H both directions.
// - Glyph pointer wraps 3FH to 00H and back.
// - Clear fills character RAM with spaces, homes pointer, unscrolls, step up.
module cdd_decoder #(
  parameter int BLINK_HALF = cdd_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register bus
  input wire cdd_pkg::cdd_apb_req_t apbReq,
  output cdd_pkg::cdd_apb_rsp_t apbRsp,
  // Display refresh scan
  input wire logic scanLine,
  input wire logic [cdd_pkg::COL_W-1:0] scanCol,
  output cdd_pkg::cdd_cell_t scanCell,
  input wire logic [cdd_pkg::GLYPH_AW-1:0] glyphScanAddr,
  output logic [7:0] glyphScanData,
  // Panel configuration
  output cdd_pkg::cdd_cfg_t displayCfg,
  output logic [cdd_pkg::SCROLL_W-1:0] scrollOffset
);
  import cdd_pkg::*;

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (BLINK_HALF < 1 || BLINK_HALF >= (1 << BLINK_CNT_W)) begin : gBadBlink
    $error("BLINK_HALF out of range for the blink counter");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [PTR_W-1:0] pointer_r;
  logic [PTR_W-1:0] pointer_nxt;
  logic charTarget_r;
  logic charTarget_nxt;
  cdd_cfg_t cfg_r;
  cdd_cfg_t cfg_nxt;
  logic [SCROLL_W-1:0] scroll_r;
  logic [SCROLL_W-1:0] scroll_nxt;
  logic [7:0] charRam [CHAR_DEPTH];
  logic [7:0] glyphRam [GLYPH_DEPTH];
  logic [31:0] prdata_r;
  logic [BLINK_CNT_W-1:0] blinkCnt_r;
  logic blinkPhase_r;
  cdd_cell_t cell_r;
  logic [7:0] glyphScan_r;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic setupPhase;
  logic accessPhase;
  logic selInstr;
  logic selData;
  logic selStatus;
  logic selScroll;
  logic mapped;
  logic instrWrite;
  logic dataWrite;
  logic dataRead;
  logic [7:0] wrByte;

  // Zero wait states: every access phase completes at its first edge
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign accessPhase = apbReq.psel & apbReq.penable;

  always_comb begin
    selInstr = 1'b0;
    selData = 1'b0;
    selStatus = 1'b0;
    selScroll = 1'b0;
    if (apbReq.paddr == OFS_INSTR) begin
      selInstr = 1'b1;
    end else if (apbReq.paddr == OFS_DATA) begin
      selData = 1'b1;
    end else if (apbReq.paddr == OFS_STATUS) begin
      selStatus = 1'b1;
    end else if (apbReq.paddr == OFS_SCROLL) begin
      selScroll = 1'b1;
    end
  end

  assign mapped = selInstr | selData | selStatus | selScroll;
  assign wrByte = apbReq.pwdata[7:0];
  // Only byte lane 0 carries the instruction or data byte
  assign instrWrite = accessPhase & apbReq.pwrite & selInstr & apbReq.pstrb[0];
  assign dataWrite = accessPhase & apbReq.pwrite & selData & apbReq.pstrb[0];
  assign dataRead = accessPhase & ~apbReq.pwrite & selData;

  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = accessPhase & ~mapped;
  assign apbRsp.prdata = prdata_r;

  // ---------------------------------------------------------------------------
  // Instruction classification
  // ---------------------------------------------------------------------------
  cdd_instr_t instr;

  // Highest set bit selects the instruction; lower bits are operands
  always_comb begin
    if (wrByte[BIT_CHAR_SET]) begin
      instr = CDD_CHAR_SET;
    end else if (wrByte[BIT_GLYPH_SET]) begin
      instr = CDD_GLYPH_SET;
    end else if (wrByte[BIT_FUNC]) begin
      instr = CDD_FUNC;
    end else if (wrByte[BIT_SHIFT]) begin
      instr = CDD_SHIFT;
    end else if (wrByte[BIT_DISP]) begin
      instr = CDD_DISP;
    end else if (wrByte[BIT_ENTRY]) begin
      instr = CDD_ENTRY;
    end else if (wrByte[BIT_HOME]) begin
      instr = CDD_HOME;
    end else if (wrByte[BIT_CLEAR]) begin
      instr = CDD_CLEAR;
    end else begin
      instr = CDD_NOP;
    end
  end

  // ---------------------------------------------------------------------------
  // Pointer and scroll stepping
  // ---------------------------------------------------------------------------
  function automatic logic [PTR_W-1:0] stepPointer(
    input logic [PTR_W-1:0] ptr,
    input logic toChar,
    input logic up
  );
    logic [PTR_W-1:0] res;
    res = up ? ptr + 7'h01 : ptr - 7'h01;
    if (toChar) begin
      if (up && ptr == LINE1_LAST) begin
        res = LINE2_FIRST;
      end else if (up && ptr == LINE2_LAST) begin
        res = HOME_ADDR;
      end else if (!up && ptr == LINE2_FIRST) begin
        res = LINE1_LAST;
      end else if (!up && ptr == HOME_ADDR) begin
        res = LINE2_LAST;
      end
    end else begin
      // Glyph space is six bits wide, so the top bit is dropped
      res = {1'b0, res[GLYPH_AW-1:0]};
    end
    return res;
  endfunction

  // Left moves the window toward higher addresses
  function automatic logic [SCROLL_W-1:0] stepScroll(
    input logic [SCROLL_W-1:0] ofs,
    input logic left
  );
    logic [SCROLL_W-1:0] res;
    if (left) begin
      res = (ofs == SCROLL_LAST) ? SCROLL_ZERO : ofs + 6'h01;
    end else begin
      res = (ofs == SCROLL_ZERO) ? SCROLL_LAST : ofs - 6'h01;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state of pointer, target, flags and scroll
  // ---------------------------------------------------------------------------
  logic clearAll;

  always_comb begin
    pointer_nxt = pointer_r;
    charTarget_nxt = charTarget_r;
    cfg_nxt = cfg_r;
    scroll_nxt = scroll_r;
    clearAll = 1'b0;
    if (instrWrite) begin
      case (instr)
        CDD_CLEAR: begin
          clearAll = 1'b1;
          pointer_nxt = HOME_ADDR;
          charTarget_nxt = 1'b1;
          scroll_nxt = SCROLL_ZERO;
          cfg_nxt.stepUp = 1'b1;
        end
        CDD_HOME: begin
          pointer_nxt = HOME_ADDR;
          charTarget_nxt = 1'b1;
          scroll_nxt = SCROLL_ZERO;
        end
        CDD_ENTRY: begin
          cfg_nxt.stepUp = wrByte[ENTRY_DIR_BIT];
          cfg_nxt.autoScroll = wrByte[ENTRY_SCROLL_BIT];
        end
        CDD_DISP: begin
          cfg_nxt.panelOn = wrByte[DISP_PANEL_BIT];
          cfg_nxt.cursorOn = wrByte[DISP_CURSOR_BIT];
          cfg_nxt.blink = wrByte[DISP_BLINK_BIT];
        end
        CDD_SHIFT: begin
          // A glyph pointer is stepped by character rules once retargeted
          pointer_nxt = stepPointer(pointer_r, 1'b1, wrByte[SHIFT_RL_BIT]);
          charTarget_nxt = 1'b1;
          if (wrByte[SHIFT_SC_BIT]) begin
            scroll_nxt = stepScroll(scroll_r, ~wrByte[SHIFT_RL_BIT]);
          end
        end
        CDD_FUNC: begin
          cfg_nxt.busWidth8 = wrByte[FUNC_DL_BIT];
          cfg_nxt.twoLines = wrByte[FUNC_N_BIT];
          cfg_nxt.luminance = {wrByte[FUNC_LUM_HI_BIT], wrByte[FUNC_LUM_LO_BIT]};
        end
        CDD_GLYPH_SET: begin
          pointer_nxt = {1'b0, wrByte[GLYPH_AW-1:0]};
          charTarget_nxt = 1'b0;
        end
        CDD_CHAR_SET: begin
          pointer_nxt = wrByte[PTR_W-1:0];
          charTarget_nxt = 1'b1;
        end
        default: begin
          pointer_nxt = pointer_r;
        end
      endcase
    end else if (dataWrite) begin
      pointer_nxt = stepPointer(pointer_r, charTarget_r, cfg_r.stepUp);
      if (charTarget_r && cfg_r.autoScroll) begin
        // Step up scrolls left, step down scrolls right
        scroll_nxt = stepScroll(scroll_r, cfg_r.stepUp);
      end
    end else if (dataRead) begin
      pointer_nxt = stepPointer(pointer_r, charTarget_r, cfg_r.stepUp);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pointer_r <= HOME_ADDR;
      charTarget_r <= 1'b1;
      scroll_r <= SCROLL_ZERO;
    end else begin
      pointer_r <= pointer_nxt;
      charTarget_r <= charTarget_nxt;
      scroll_r <= scroll_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Character RAM
  // ---------------------------------------------------------------------------
  // Held in flops so that reset and clear can fill every cell in one cycle
  for (genvar i = 0; i < CHAR_DEPTH; i++) begin : gChar
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        charRam[i] <= SPACE_CODE;
      end else if (clearAll) begin
        charRam[i] <= SPACE_CODE;
      end else if (dataWrite && charTarget_r && pointer_r == PTR_W'(i)) begin
        charRam[i] <= wrByte;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Glyph RAM
  // ---------------------------------------------------------------------------
  // Not cleared by reset or clear; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (dataWrite && !charTarget_r) begin
      glyphRam[pointer_r[GLYPH_AW-1:0]] <= wrByte;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  // Captured in the setup phase, before the access edge steps the pointer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPhase && !apbReq.pwrite) begin
      if (selInstr) begin
        prdata_r <= {24'h00_0000, BUSY_FLAG, pointer_r};
      end else if (selData) begin
        if (charTarget_r) begin
          prdata_r <= {24'h00_0000, charRam[pointer_r]};
        end else begin
          prdata_r <= {24'h00_0000, glyphRam[pointer_r[GLYPH_AW-1:0]]};
        end
      end else if (selStatus) begin
        prdata_r <= {21'h00_0000, blinkPhase_r, charTarget_r, cfg_r};
      end else if (selScroll) begin
        prdata_r <= {26'h000_0000, scroll_r};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Blink timebase
  // ---------------------------------------------------------------------------
  localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_HALF - 1);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      blinkCnt_r <= '0;
      blinkPhase_r <= 1'b0;
    end else if (blinkCnt_r == BLINK_LAST) begin
      blinkCnt_r <= '0;
      blinkPhase_r <= ~blinkPhase_r;
    end else begin
      blinkCnt_r <= blinkCnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Refresh scan
  // ---------------------------------------------------------------------------
  logic [SCROLL_W-1:0] colSum;
  logic [SCROLL_W-1:0] colPos;
  logic [PTR_W-1:0] cellAddr;
  logic atCursor;

  assign colSum = SCROLL_W'(scanCol) + scroll_r;
  assign colPos = (colSum >= LINE_LEN) ? colSum - LINE_LEN : colSum;
  assign cellAddr = (scanLine ? LINE2_FIRST : HOME_ADDR) + PTR_W'(colPos);
  // The cursor exists only while the pointer addresses character RAM
  assign atCursor = charTarget_r && cellAddr == pointer_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cell_r <= '0;
      glyphScan_r <= 8'h00;
    end else begin
      cell_r.code <= charRam[cellAddr];
      // Single-line mode leaves the second row dark
      cell_r.blank <= ~cfg_r.panelOn | (scanLine & ~cfg_r.twoLines);
      cell_r.cursorRow <= cfg_r.cursorOn & atCursor;
      cell_r.allPixelsOn <= cfg_r.blink & blinkPhase_r & atCursor;
      glyphScan_r <= glyphRam[glyphScanAddr];
    end
  end

  assign scanCell = cell_r;
  assign glyphScanData = glyphScan_r;
  assign displayCfg = cfg_r;
  assign scrollOffset = scroll_r;

endmodule

// *** cdd_decoder_properties.sv ***
// Port assertions for the character display decoder
`timescale 1ns/1ps
module cdd_decoder_properties #(
  parameter int BLINK_HALF = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus and display ports
  input wire cdd_pkg::cdd_apb_req_t apbReq,
  input wire cdd_pkg::cdd_apb_rsp_t apbRsp,
  input wire logic scanLine,
  input wire logic [cdd_pkg::COL_W-1:0] scanCol,
  input wire cdd_pkg::cdd_cell_t scanCell,
  input wire logic [cdd_pkg::GLYPH_AW-1:0] glyphScanAddr,
  input wire logic [7:0] glyphScanData,
  input wire cdd_pkg::cdd_cfg_t displayCfg,
  input wire logic [cdd_pkg::SCROLL_W-1:0] scrollOffset
);
  import cdd_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  logic iw;
  logic [7:0] op;
  assign iw = apbReq.psel && apbReq.penable && apbReq.pwrite && apbReq.pstrb[0]
    && apbReq.paddr == OFS_INSTR;
  assign op = apbReq.pwdata[7:0];
  function automatic logic [SCROLL_W-1:0] step(logic [SCROLL_W-1:0] o, logic lft);
    if (lft) return (o == SCROLL_LAST) ? SCROLL_ZERO : o + 1'b1;
    return (o == SCROLL_ZERO) ? SCROLL_LAST : o - 1'b1;
  endfunction
  // ----
  // Assertions
  // ----
  AST_ZERO_WAIT: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
    else $error("access without ready");
  AST_HOME: assert property (iw && op[7:1] == 7'h01 |=> scrollOffset == SCROLL_ZERO)
    else $error("home left a scroll");
  AST_CLEAR: assert property (iw && op == 8'h01 |=> !scrollOffset && displayCfg.stepUp)
    else $error("clear state wrong");
  AST_ENTRY: assert property (iw && op[7:2] == 6'h01
    |=> {displayCfg.stepUp, displayCfg.autoScroll} == $past(op[1:0]))
    else $error("entry flags wrong");
  AST_DISP: assert property (iw && op[7:3] == 5'h01
    |=> {displayCfg.panelOn, displayCfg.cursorOn, displayCfg.blink} == $past(op[2:0]))
    else $error("display flags wrong");
  AST_FUNC: assert property (iw && op[7:5] == 3'h1
    |=> {displayCfg.busWidth8, displayCfg.twoLines, displayCfg.luminance}
      == {$past(op[4:3]), $past(op[1:0])})
    else $error("function flags wrong");
  AST_SHIFT: assert property (iw && op[7:3] == 5'h03
    |=> scrollOffset == step($past(scrollOffset), !$past(op[2])))
    else $error("display shift wrong");
  AST_MOVE: assert property (iw && op[7:3] == 5'h02 |=> $stable(scrollOffset))
    else $error("cursor move scrolled");
  AST_CFG_HOLD: assert property (!iw |=> $stable(displayCfg))
    else $error("flags changed without instruction");
  AST_BLANK: assert property ($past(rstn) |-> scanCell.blank ==
    $past(!displayCfg.panelOn || (scanLine && !displayCfg.twoLines)))
    else $error("blank wrong");
  AST_NO_CURSOR: assert property ($past(rstn) && !$past(displayCfg.cursorOn)
    |-> !scanCell.cursorRow)
    else $error("cursor drawn while off");
  AST_NO_BLINK: assert property ($past(rstn) && !$past(displayCfg.blink)
    |-> !scanCell.allPixelsOn)
    else $error("blink while off");
  COV_CLEAR: cover property (iw && op == 8'h01);
  COV_SCROLL: cover property (iw && op[7:3] == 5'h03);
  COV_BLINK: cover property (scanCell.allPixelsOn);
endmodule

bind cdd_decoder cdd_decoder_properties #(.BLINK_HALF(BLINK_HALF)) cdd_props (
  .core_clk(core_clk), .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
  .scanLine(scanLine), .scanCol(scanCol), .scanCell(scanCell),
  .glyphScanAddr(glyphScanAddr), .glyphScanData(glyphScanData),
  .displayCfg(displayCfg), .scrollOffset(scrollOffset));

// *** cdd_host_model.sv ***
// Host model: bus master issuing instructions and data
`timescale 1ns/1ps
module cdd_host_model (
  // Clock
  input wire logic core_clk,
  // Register bus
  output cdd_pkg::cdd_apb_req_t apbReq,
  input wire cdd_pkg::cdd_apb_rsp_t apbRsp
);
  import cdd_pkg::*;
  initial apbReq = '0;
  // Never polls busy; next transfer may start at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    apbReq <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:wd, pstrb:4'hF};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk);
      if (apbRsp.pready === 1'b1) break;
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    // Released lines show junk, not the last value
    apbReq <= '{psel:1'b0, penable:1'b0, pwrite:~w, paddr:~a, pwdata:~wd, pstrb:4'h0};
    if (n == 16) begin
      cdd_decoder_bench.error_cnt++;
      cdd_decoder_bench.finish_test();
    end
  endtask
endmodule

// *** cdd_decoder_bench.sv ***
// Self-checking bench for the character display decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module cdd_decoder_bench;
  import cdd_pkg::*;
  localparam int HALF = 8;
  logic core_clk = 0;
  logic rstn = 0;
  logic scanLine = 0;
  logic [COL_W-1:0] scanCol = '0;
  logic [GLYPH_AW-1:0] glyphScanAddr = '0;
  cdd_apb_req_t apbReq;
  cdd_apb_rsp_t apbRsp;
  cdd_cell_t scanCell;
  logic [7:0] glyphScanData;
  cdd_cfg_t displayCfg;
  logic [SCROLL_W-1:0] scrollOffset;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] rd;
  logic err;
  always #12.5 core_clk = ~core_clk;
  cdd_decoder #(.BLINK_HALF(HALF)) cdd_decoder_inst (.core_clk(core_clk), .rstn(rstn),
    .apbReq(apbReq), .apbRsp(apbRsp), .scanLine(scanLine), .scanCol(scanCol),
    .scanCell(scanCell), .glyphScanAddr(glyphScanAddr), .glyphScanData(glyphScanData),
    .displayCfg(displayCfg), .scrollOffset(scrollOffset));
  cdd_host_model cdd_host_model_inst (.core_clk(core_clk), .apbReq(apbReq), .apbRsp(apbRsp));
  // ----
  // Helpers
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cdd_host_model_inst.xfer(1'b1, a, {24'h0, d}, rd, err);
  endtask
  task automatic rdw(input logic [7:0] a);
    cdd_host_model_inst.xfer(1'b0, a, 32'h0, rd, err);
  endtask
  task automatic ins(input logic [7:0] d);
    wr(OFS_INSTR, d);
  endtask
  task automatic ptr_is(input logic [6:0] e);
    rdw(OFS_INSTR);
    `CHK("pointer", {25'h0, e}, rd)
  endtask
  task automatic ofs_is(input logic [5:0] e);
    #1;
    `CHK("scroll", e, scrollOffset)
  endtask
  task automatic scan(input logic ln, input logic [4:0] c, input logic [5:0] g);
    @(posedge core_clk);
    scanLine <= ln;
    scanCol <= c;
    glyphScanAddr <= g;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rdw(OFS_STATUS);
    `CHK("flags", 10'h30C, rd[9:0])
    ptr_is(7'h00);
    rdw(OFS_DATA);
    `CHK("space", 32'h20, rd)
    ptr_is(7'h01);
    ofs_is(6'h00);
    rdw(8'h10);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_wrap;
    ins(8'hA7);
    wr(OFS_DATA, 8'h41);
    ptr_is(7'h40);
    ins(8'h04);
    ins(8'h80);
    wr(OFS_DATA, 8'h42);
    ptr_is(7'h67);
    ins(8'hA7);
    rdw(OFS_DATA);
    `CHK("char read", 32'h41, rd)
    ins(8'h38);
    ptr_is(7'h26);
  endtask
  task automatic t_glyph;
    ins(8'h06);
    ins(8'h7F);
    ptr_is(7'h3F);
    wr(OFS_DATA, 8'h15);
    ptr_is(7'h00);
    ins(8'h04);
    wr(OFS_DATA, 8'h16);
    ptr_is(7'h3F);
    rdw(OFS_DATA);
    `CHK("glyph read", 32'h15, rd)
    ins(8'h7F);
    scan(1'b0, 5'd0, 6'h3F);
    `CHK("glyph", 8'h15, glyphScanData)
    ins(8'h14);
    ptr_is(7'h40);
    rdw(OFS_STATUS);
    `CHK("char target", 1'b1, rd[9])
    ofs_is(6'h00);
    ins(8'h10);
    ptr_is(7'h27);
  endtask
  task automatic t_scroll;
    ins(8'h07);
    ins(8'h80);
    wr(OFS_DATA, 8'h33);
    ofs_is(6'h01);
    rdw(OFS_DATA);
    ofs_is(6'h01);
    ins(8'h05);
    wr(OFS_DATA, 8'h34);
    ofs_is(6'h00);
    ins(8'h1B);
    ofs_is(6'h01);
    ins(8'h1C);
    ins(8'h1C);
    ofs_is(6'h27);
    rdw(OFS_SCROLL);
    `CHK("scroll reg", 32'h27, rd)
    ins(8'h03);
    ofs_is(6'h00);
    ptr_is(7'h00);
  endtask
  task automatic t_func;
    for (int i = 0; i < 4; i++) begin
      ins(8'h3C | i[7:0]);
      #1;
      `CHK("luminance", i[1:0], displayCfg.luminance)
    end
    ins(8'h20);
    #1;
    `CHK("width lines", 2'b00, {displayCfg.busWidth8, displayCfg.twoLines})
    ins(8'h0C);
    scan(1'b1, 5'd0, 6'h3F);
    `CHK("one line", 1'b1, scanCell.blank)
    scan(1'b0, 5'd0, 6'h3F);
    `CHK("panel on", 1'b0, scanCell.blank)
    ins(8'h38);
    ins(8'h08);
    scan(1'b1, 5'd0, 6'h3F);
    `CHK("panel off", 1'b1, scanCell.blank)
  endtask
  task automatic t_cursor;
    int n;
    n = 0;
    ins(8'h06);
    ins(8'h85);
    wr(OFS_DATA, 8'h5A);
    ins(8'h85);
    ins(8'h0E);
    scan(1'b0, 5'd5, 6'h3F);
    `CHK("code", 8'h5A, scanCell.code)
    `CHK("cursor", 1'b1, scanCell.cursorRow)
    scan(1'b0, 5'd6, 6'h3F);
    `CHK("no cursor", 1'b0, scanCell.cursorRow)
    ins(8'h0F);
    scan(1'b0, 5'd5, 6'h3F);
    repeat (4 * HALF) begin
      @(posedge core_clk);
      #1;
      n += scanCell.allPixelsOn;
    end
    `CHK("blink duty", 2 * HALF, n)
  endtask
  task automatic t_clear;
    ins(8'h04);
    ins(8'h81);
    wr(OFS_DATA, 8'h77);
    ins(8'h01);
    ptr_is(7'h00);
    rdw(OFS_STATUS);
    `CHK("step up", 1'b1, rd[8])
    ins(8'h81);
    rdw(OFS_DATA);
    `CHK("cleared", 32'h20, rd)
    `CHK("glyph kept", 8'h15, glyphScanData)
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_wrap();
    t_glyph();
    t_scroll();
    t_func();
    t_cursor();
    t_clear();
    finish_test();
  end
endmodule
